// ---- rtl/bmms_top.v ----
// Purpose: memory map decode, boot select, flash control and fast program port
// Assumes: one 25 MHz clock, all inputs synchronous to it
// Notes:   nonvolatile bit image reloads while reset is held
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
`include "bmms_defs.vh"

// Contract
// - SRAM is decoded at 0x2000_0000 for bus reads and writes.
// - SRAM bit-band alias window ends 0x23FF_FFFF, one word per SRAM bit.
// - ROM always decoded at 0x0080_0000 whatever the boot selection.
// - flash is one bank of 256-byte pages, 1024 pages largest.
// - a 128-byte write buffer is filled by 32-bit writes.
// - software selects 128-bit or 64-bit flash access width.
// - three nonvolatile bits, each set or cleared by commands.
// - processor boots from address 0x0, whatever memory is there.
// - nonvolatile bit 1 set maps flash at 0x0, cleared maps ROM.
// - erase input clears nonvolatile bit 1; the boot map stays as latched until the next reset.
// - fast port accepts read, program, page/full erase, lock, unlock, protect.
// - peripheral region lies in bit-band region, also decoded in alias.
// - erase debounced on slow clock; under 100 ms ignored, over 220 ms acts.
// - erase pin used as general output never erases anything.
module bmms_top #(
	parameter SRAM_BYTES  = 32'h0000_6000,
	parameter ROM_BYTES   = 32'h0000_4000,
	parameter FLASH_PAGES = `BMMS_PAGES,
	parameter SLOW_DIV    = `BMMS_SLOW_DIV,
	parameter ERASE_TICKS = `BMMS_ERASE_ACT_TICKS
) (
	// clock and reset
	input  wire        ref_clk_i,
	input  wire        rst_n_i,
	// register port
	input  wire [7:0]  reg_addr_i,
	input  wire [31:0] reg_wdata_i,
	input  wire        reg_wr_i,
	input  wire        reg_rd_i,
	output reg  [31:0] reg_rdata_o,
	// system bus decode
	input  wire        sys_valid_i,
	input  wire [31:0] sys_addr_i,
	output reg         sys_hit_o,
	output reg         sys_err_o,
	output reg  [2:0]  sys_target_o,
	output reg  [31:0] sys_offset_o,
	output reg         sys_bitband_o,
	output reg  [2:0]  sys_bit_o,
	// flash array side
	input  wire        flash_busy_i,
	output reg         flash_op_o,
	output reg  [1:0]  flash_op_kind_o,
	output reg  [9:0]  flash_page_o,
	output wire        flash_wide_o,
	input  wire [4:0]  wbuf_idx_i,
	output reg  [31:0] wbuf_data_o,
	// nonvolatile bits
	input  wire [2:0]  nvm_image_i,
	output wire [2:0]  nonvolatile_config_bits_o,
	output wire        boot_flash_o,
	// fast programming port
	input  wire        test_mode_pin_i,
	input  wire        port_a_line_0_i,
	input  wire        port_a_line_1_i,
	input  wire        fpp_cmd_valid_i,
	input  wire [3:0]  fpp_cmd_i,
	output reg         fpp_mode_o,
	output reg         fpp_accept_o,
	output reg         fpp_reject_o,
	output reg  [3:0]  fpp_cmd_o,
	// erase pin
	input  wire        erase_pin_i,
	input  wire        erase_pin_gpio_i,
	output wire        erase_fire_o
);

	// ****************************************
	// declarations
	// ****************************************
	reg  [31:0] wbuf_mem [0:`BMMS_WBUF_WORDS-1];
	reg         wide_reg;
	reg  [2:0]  nv_reg;
	reg  [2:0]  nv_next;
	reg         boot_reg;
	reg         cmd_err_reg;
	reg         cmd_err_next;
	reg         op_next;
	reg  [1:0]  kind_next;
	reg  [2:0]  tgt_next;
	reg  [31:0] off_next;
	reg         bb_next;
	reg  [2:0]  bit_next;
	reg  [31:0] rd_next;
	reg  [31:0] bb_byte;
	wire [31:0] flash_bytes;
	wire        cmd_wr;
	wire [3:0]  cmd_code;
	wire [1:0]  cmd_nv;
	wire [9:0]  cmd_page;
	wire        page_ok;
	wire        erase_lvl;

	// ****************************************
	// functions
	// ****************************************
	// true when a lies in [base, base+span)
	function in_win;
		input [31:0] a;
		input [31:0] base;
		input [31:0] span;
		begin
			in_win = (a >= base) && (a - base < span);
		end
	endfunction

	// alias word address to byte offset inside its region
	function [31:0] alias_byte;
		input [31:0] a;
		input [31:0] base;
		reg   [31:0] d;
		begin
			d = a - base;
			alias_byte = {12'h000, d[24:5]};
		end
	endfunction

	// fast port command is one of the known codes
	function fp_known;
		input [3:0] c;
		begin
			case (c)
				`BMMS_FP_READ,
				`BMMS_FP_PROG,
				`BMMS_FP_PERASE,
				`BMMS_FP_FERASE,
				`BMMS_FP_LOCK,
				`BMMS_FP_UNLOCK,
				`BMMS_FP_PROT: fp_known = 1'b1;
				default:       fp_known = 1'b0;
			endcase
		end
	endfunction

	// ****************************************
	// address decode
	// ****************************************
	// flash size follows the page count of the variant
	assign flash_bytes = FLASH_PAGES * `BMMS_PAGE_BYTES;

	// combinational map, registered below to cut bus timing
	always @* begin
		tgt_next = `BMMS_TGT_NONE;
		off_next = 32'h0000_0000;
		bb_next  = 1'b0;
		bit_next = 3'h0;
		bb_byte  = 32'h0000_0000;
		if (in_win(sys_addr_i, 32'h0000_0000, `BMMS_BOOT_SPAN)) begin
			// reset vector fetch lands here whatever is mapped
			off_next = sys_addr_i;
			if (boot_reg) begin
				if (sys_addr_i < flash_bytes)
					tgt_next = `BMMS_TGT_FLASH;
			end else if (sys_addr_i < ROM_BYTES) begin
				tgt_next = `BMMS_TGT_ROM;
			end
		end else if (in_win(sys_addr_i, `BMMS_FLASH_BASE, flash_bytes)) begin
			tgt_next = `BMMS_TGT_FLASH;
			off_next = sys_addr_i - `BMMS_FLASH_BASE;
		end else if (in_win(sys_addr_i, `BMMS_ROM_BASE, ROM_BYTES)) begin
			tgt_next = `BMMS_TGT_ROM;
			off_next = sys_addr_i - `BMMS_ROM_BASE;
		end else if (in_win(sys_addr_i, `BMMS_SRAM_BASE, SRAM_BYTES)) begin
			tgt_next = `BMMS_TGT_SRAM;
			off_next = sys_addr_i - `BMMS_SRAM_BASE;
		end else if (in_win(sys_addr_i, `BMMS_SRAM_BB, `BMMS_ALIAS_SPAN)) begin
			bb_byte = alias_byte(sys_addr_i, `BMMS_SRAM_BB);
			// alias beyond the fitted SRAM is an error, not a wrap
			if (bb_byte < SRAM_BYTES) begin
				tgt_next = `BMMS_TGT_SRAM;
				off_next = bb_byte;
				bb_next  = 1'b1;
				bit_next = sys_addr_i[4:2];
			end
		end else if (in_win(sys_addr_i, `BMMS_PERI_BASE, `BMMS_REGION_SPAN)) begin
			tgt_next = `BMMS_TGT_PERI;
			off_next = sys_addr_i - `BMMS_PERI_BASE;
		end else if (in_win(sys_addr_i, `BMMS_PERI_BB, `BMMS_ALIAS_SPAN)) begin
			tgt_next = `BMMS_TGT_PERI;
			off_next = alias_byte(sys_addr_i, `BMMS_PERI_BB);
			bb_next  = 1'b1;
			bit_next = sys_addr_i[4:2];
		end
	end

	// decode result, one cycle after the request
	always @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			sys_hit_o     <= 1'b0;
			sys_err_o     <= 1'b0;
			sys_target_o  <= `BMMS_TGT_NONE;
			sys_offset_o  <= 32'h0000_0000;
			sys_bitband_o <= 1'b0;
			sys_bit_o     <= 3'h0;
		end else begin
			sys_hit_o     <= sys_valid_i && tgt_next != `BMMS_TGT_NONE;
			sys_err_o     <= sys_valid_i && tgt_next == `BMMS_TGT_NONE;
			sys_target_o  <= sys_valid_i ? tgt_next : `BMMS_TGT_NONE;
			sys_offset_o  <= sys_valid_i ? off_next : 32'h0000_0000;
			sys_bitband_o <= sys_valid_i && bb_next;
			sys_bit_o     <= sys_valid_i ? bit_next : 3'h0;
		end
	end

	// ****************************************
	// command decode
	// ****************************************
	assign cmd_wr   = reg_wr_i && reg_addr_i == `BMMS_REG_CMD;
	assign cmd_code = reg_wdata_i[3:0];
	assign cmd_nv   = reg_wdata_i[`BMMS_CMD_NV_LSB +: 2];
	assign cmd_page = reg_wdata_i[`BMMS_CMD_PG_LSB +: `BMMS_PAGE_W];
	assign page_ok  = {22'h000000, cmd_page} < FLASH_PAGES;

	// erase pin only counts while it is a system pin
	assign erase_lvl = erase_pin_i && !erase_pin_gpio_i;

	// next nonvolatile bits, command result and flash request
	always @* begin
		nv_next      = nv_reg;
		cmd_err_next = cmd_wr ? 1'b0 : cmd_err_reg;
		op_next      = 1'b0;
		kind_next    = 2'h0;
		if (cmd_wr) begin
			case (cmd_code)
				`BMMS_CMD_SETNV: begin
					if (cmd_nv < `BMMS_NV_BITS)
						nv_next[cmd_nv] = 1'b1;
					else
						cmd_err_next = 1'b1;
				end
				`BMMS_CMD_CLRNV: begin
					if (cmd_nv < `BMMS_NV_BITS)
						nv_next[cmd_nv] = 1'b0;
					else
						cmd_err_next = 1'b1;
				end
				`BMMS_CMD_PROG,
				`BMMS_CMD_ERASE: begin
					// a busy array or a page past the end is refused
					if (flash_busy_i || !page_ok) begin
						cmd_err_next = 1'b1;
					end else begin
						op_next   = 1'b1;
						kind_next = (cmd_code == `BMMS_CMD_PROG) ?
							`BMMS_OP_PROG : `BMMS_OP_ERASE;
					end
				end
				default: cmd_err_next = 1'b1;
			endcase
		end
		// long erase press beats a same-cycle set of the boot bit
		if (erase_fire_o)
			nv_next[`BMMS_NV_BOOT] = 1'b0;
	end

	// ****************************************
	// control state
	// ****************************************
	always @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			wide_reg        <= `BMMS_CTRL_RESET;
			nv_reg          <= nvm_image_i;
			// boot choice caught while reset is held, frozen after
			boot_reg        <= nvm_image_i[`BMMS_NV_BOOT];
			cmd_err_reg     <= 1'b0;
			flash_op_o      <= 1'b0;
			flash_op_kind_o <= 2'h0;
			flash_page_o    <= 10'h000;
		end else begin
			if (reg_wr_i && reg_addr_i == `BMMS_REG_CTRL)
				wide_reg <= reg_wdata_i[0];
			nv_reg      <= nv_next;
			cmd_err_reg <= cmd_err_next;
			flash_op_o  <= op_next;
			if (op_next) begin
				flash_op_kind_o <= kind_next;
				flash_page_o    <= cmd_page;
			end
		end
	end

	assign flash_wide_o              = wide_reg;
	assign nonvolatile_config_bits_o = nv_reg;
	assign boot_flash_o              = boot_reg;

	// ****************************************
	// write buffer
	// ****************************************
	// no reset on the array; contents are don't-care until written
	always @(posedge ref_clk_i) begin
		if (reg_wr_i && reg_addr_i[7])
			wbuf_mem[reg_addr_i[6:2]] <= reg_wdata_i;
	end

	// array reads the buffer one word per cycle
	always @(posedge ref_clk_i) begin
		if (!rst_n_i)
			wbuf_data_o <= 32'h0000_0000;
		else
			wbuf_data_o <= wbuf_mem[wbuf_idx_i];
	end

	// ****************************************
	// register read
	// ****************************************
	always @* begin
		rd_next = 32'h0000_0000;
		if (reg_addr_i[7]) begin
			rd_next = wbuf_mem[reg_addr_i[6:2]];
		end else begin
			case (reg_addr_i)
				`BMMS_REG_CTRL: rd_next = {31'h00000000, wide_reg};
				`BMMS_REG_STAT: rd_next = {24'h000000, flash_busy_i,
					fpp_mode_o, boot_reg, nv_reg, 1'b0, cmd_err_reg};
				// flash descriptor keeps software generic
				`BMMS_REG_DESC: rd_next = {FLASH_PAGES[15:0],
					16'h0100};
				default:        rd_next = 32'h0000_0000;
			endcase
		end
	end

	// read data valid only the cycle after the strobe
	always @(posedge ref_clk_i) begin
		if (!rst_n_i)
			reg_rdata_o <= 32'h0000_0000;
		else
			reg_rdata_o <= reg_rd_i ? rd_next : 32'h0000_0000;
	end

	// ****************************************
	// fast programming port
	// ****************************************
	always @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			fpp_mode_o   <= 1'b0;
			fpp_accept_o <= 1'b0;
			fpp_reject_o <= 1'b0;
			fpp_cmd_o    <= 4'h0;
		end else begin
			// entry needs all three lines low together
			fpp_mode_o <= !test_mode_pin_i && !port_a_line_0_i
				&& !port_a_line_1_i;
			fpp_accept_o <= fpp_cmd_valid_i && fpp_mode_o
				&& fp_known(fpp_cmd_i);
			fpp_reject_o <= fpp_cmd_valid_i && !(fpp_mode_o
				&& fp_known(fpp_cmd_i));
			if (fpp_cmd_valid_i && fpp_mode_o && fp_known(fpp_cmd_i))
				fpp_cmd_o <= fpp_cmd_i;
		end
	end

	// ****************************************
	// erase debounce
	// ****************************************
	bmms_debounce #(
		.SLOW_DIV  (SLOW_DIV),
		.ACT_TICKS (ERASE_TICKS)
	) u_erase (
		.clk_i   (ref_clk_i),
		.rst_n_i (rst_n_i),
		.level_i (erase_lvl),
		.fire_o  (erase_fire_o)
	);

endmodule // bmms_top

// ---- rtl/bmms_defs.vh ----
// Purpose: constants for the boot memory map select block
// Assumes: included by bare name from rtl files
// Notes:   offsets are byte addresses on the plain register port
`ifndef BMMS_DEFS_VH
`define BMMS_DEFS_VH

// ****************************************
// clock and timing
// ****************************************
`define BMMS_CLK_HZ          25000000
`define BMMS_SLOW_HZ         32768
`define BMMS_SLOW_DIV        (`BMMS_CLK_HZ / `BMMS_SLOW_HZ)
`define BMMS_ERASE_IGN_MS    100
`define BMMS_ERASE_ACT_MS    220
`define BMMS_ERASE_ACT_TICKS ((`BMMS_ERASE_ACT_MS * `BMMS_SLOW_HZ + 999) / 1000)

// ****************************************
// system address map
// ****************************************
`define BMMS_BOOT_SPAN   32'h0040_0000
`define BMMS_FLASH_BASE  32'h0040_0000
`define BMMS_ROM_BASE    32'h0080_0000
`define BMMS_SRAM_BASE   32'h2000_0000
`define BMMS_SRAM_BB     32'h2200_0000
`define BMMS_PERI_BASE   32'h4000_0000
`define BMMS_PERI_BB     32'h4200_0000
`define BMMS_REGION_SPAN 32'h0010_0000
`define BMMS_ALIAS_SPAN  32'h0200_0000

// ****************************************
// flash geometry
// ****************************************
`define BMMS_PAGE_BYTES  256
`define BMMS_PAGES       1024
`define BMMS_PAGE_W      10
`define BMMS_WBUF_WORDS  32
`define BMMS_WBUF_AW     5

// ****************************************
// decode targets
// ****************************************
`define BMMS_TGT_NONE  3'h0
`define BMMS_TGT_SRAM  3'h1
`define BMMS_TGT_ROM   3'h2
`define BMMS_TGT_FLASH 3'h3
`define BMMS_TGT_PERI  3'h4

// ****************************************
// register offsets and fields
// ****************************************
`define BMMS_REG_CTRL   8'h00
`define BMMS_REG_CMD    8'h04
`define BMMS_REG_STAT   8'h08
`define BMMS_REG_DESC   8'h0C
`define BMMS_REG_WBUF   8'h80
`define BMMS_CTRL_RESET 1'h1
`define BMMS_CMD_SETNV  4'h1
`define BMMS_CMD_CLRNV  4'h2
`define BMMS_CMD_PROG   4'h3
`define BMMS_CMD_ERASE  4'h4
`define BMMS_CMD_NV_LSB 8
`define BMMS_CMD_PG_LSB 16
`define BMMS_OP_PROG    2'h1
`define BMMS_OP_ERASE   2'h2
`define BMMS_NV_BITS    3
`define BMMS_NV_BOOT    1

// ****************************************
// fast programming port commands
// ****************************************
`define BMMS_FP_READ   4'h0
`define BMMS_FP_PROG   4'h1
`define BMMS_FP_PERASE 4'h2
`define BMMS_FP_FERASE 4'h3
`define BMMS_FP_LOCK   4'h4
`define BMMS_FP_UNLOCK 4'h5
`define BMMS_FP_PROT   4'h6

`endif

// ---- rtl/bmms_debounce.v ----
// Purpose: erase input debouncer on a slow tick
// Assumes: level_i synchronous to clk_i
// Notes:   one pulse per long press; short highs never fire
`timescale 1ns/1ns
`include "bmms_defs.vh"
module bmms_debounce #(
	parameter SLOW_DIV  = `BMMS_SLOW_DIV,
	parameter ACT_TICKS = `BMMS_ERASE_ACT_TICKS
) (
	// clock and reset
	input  wire        clk_i,
	input  wire        rst_n_i,
	// level in, event out
	input  wire        level_i,
	output reg         fire_o
);

	reg  [9:0]  div_reg;
	reg  [15:0] cnt_reg;
	wire        tick;

	// slow tick enable, stands in for the slow clock
	assign tick = (div_reg == SLOW_DIV[9:0] - 10'h001);

	// ****************************************
	// count time held high
	// ****************************************
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			div_reg <= 10'h000;
			cnt_reg <= 16'h0000;
			fire_o  <= 1'b0;
		end else begin
			div_reg <= tick ? 10'h000 : div_reg + 10'h001;
			fire_o  <= 1'b0;
			if (!level_i) begin
				cnt_reg <= 16'h0000;
			end else if (tick && cnt_reg != ACT_TICKS[15:0]) begin
				cnt_reg <= cnt_reg + 16'h0001;
				// saturate so a held pin fires once only
				if (cnt_reg == ACT_TICKS[15:0] - 16'h0001)
					fire_o <= 1'b1;
			end
		end
	end

endmodule // bmms_debounce

// ---- verification/bmms_assertions.sv ----
// Purpose: port checks on the boot map block
// Assumes: default memory sizes, bound from the bench top
// Notes:   one clock domain, reset is synchronous
`timescale 1ns/1ns
module bmms_chk (
	// clock and reset
	input logic        ref_clk_i,
	input logic        rst_n_i,
	// inputs watched
	input logic        sys_valid_i,
	input logic [31:0] sys_addr_i,
	input logic        reg_wr_i,
	input logic [7:0]  reg_addr_i,
	input logic [31:0] reg_wdata_i,
	input logic        flash_busy_i,
	input logic        erase_pin_gpio_i,
	input logic        fpp_cmd_valid_i,
	input logic [3:0]  fpp_cmd_i,
	// outputs watched
	input logic        sys_hit_o,
	input logic [2:0]  sys_target_o,
	input logic        sys_bitband_o,
	input logic [2:0]  sys_bit_o,
	input logic        flash_op_o,
	input logic [1:0]  flash_op_kind_o,
	input logic [9:0]  flash_page_o,
	input logic [2:0]  nonvolatile_config_bits_o,
	input logic        boot_flash_o,
	input logic        erase_fire_o,
	input logic        fpp_mode_o,
	input logic        fpp_accept_o,
	input logic        fpp_reject_o,
	input logic [3:0]  fpp_cmd_o
);
	// ****************
	// properties
	// ****************
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	a_sram_decode: assert property (
		sys_valid_i && sys_addr_i[31:16] == 16'h2000 && sys_addr_i[15:0] < 16'h6000
		|=> sys_hit_o && sys_target_o == 3'h1) else $error("sram decode wrong");
	a_alias_bit: assert property (
		sys_valid_i && sys_addr_i[31:25] == 7'h11 && sys_addr_i[24:5] < 20'h06000
		|=> sys_bitband_o && sys_target_o == 3'h1 && sys_bit_o == $past(sys_addr_i[4:2]))
		else $error("sram alias wrong");
	a_rom_fixed: assert property (
		sys_valid_i && sys_addr_i[31:14] == 18'h00200 |=> sys_hit_o && sys_target_o == 3'h2)
		else $error("rom decode wrong");
	a_boot_map: assert property (
		sys_valid_i && sys_addr_i[31:14] == 18'h0
		|=> sys_hit_o && sys_target_o == (boot_flash_o ? 3'h3 : 3'h2))
		else $error("boot window wrong");
	a_peri_alias: assert property (
		sys_valid_i && sys_addr_i[31:25] == 7'h21 |=> sys_bitband_o && sys_target_o == 3'h4)
		else $error("peripheral alias wrong");
	a_boot_stable: assert property (
		$past(rst_n_i) |-> $stable(boot_flash_o)) else $error("boot map moved");
	a_prog_start: assert property (
		reg_wr_i && reg_addr_i == 8'h04 && reg_wdata_i[3:0] == 4'h3 && !flash_busy_i
		|=> flash_op_o && flash_op_kind_o == 2'h1 && flash_page_o == $past(reg_wdata_i[25:16]))
		else $error("program start wrong");
	a_erase_clears: assert property (
		erase_fire_o |=> !nonvolatile_config_bits_o[1]) else $error("erase kept boot bit");
	a_gpio_quiet: assert property (
		erase_pin_gpio_i && $past(erase_pin_gpio_i) |-> !erase_fire_o)
		else $error("erase fired as gpio");
	a_fpp_accept: assert property (
		fpp_cmd_valid_i && fpp_mode_o && fpp_cmd_i <= 4'h6
		|=> fpp_accept_o && !fpp_reject_o && fpp_cmd_o == $past(fpp_cmd_i))
		else $error("fast port refused");
endmodule // bmms_chk

// ---- verification/bmms_master_model.sv ----
// Purpose: bus master stand-in issuing decode requests
// Assumes: one request at a time, driven after rising edges
// Notes:   idle address shows the inverse, never the last value
`timescale 1ns/1ns
module bmms_master_model (
	// clock
	input  logic        clk_i,
	// request and answer
	output logic        sys_valid_o,
	output logic [31:0] sys_addr_o,
	input  logic        sys_hit_i,
	input  logic [2:0]  sys_target_i
);
	// ****************
	// access
	// ****************
	initial begin
		sys_valid_o = 1'b0;
		sys_addr_o  = 32'hFFFF_FFFF;
	end
	// answer read in the settled half of the next cycle
	task automatic access(input logic [31:0] a, output logic h, output logic [2:0] t);
		@(posedge clk_i);
		sys_valid_o <= 1'b1;
		sys_addr_o  <= a;
		@(posedge clk_i);
		sys_valid_o <= 1'b0;
		sys_addr_o  <= ~a; // stale address would hide decode slips
		@(negedge clk_i);
		h = sys_hit_i;
		t = sys_target_i;
	endtask
	// first fetch after reset
	task automatic boot_fetch(output logic h, output logic [2:0] t);
		access(32'h0000_0000, h, t);
	endtask
endmodule // bmms_master_model

// ---- verification/bmms_top_tb.sv ----
// Purpose: self-checking bench for the boot map block
// Assumes: short slow divider and erase count for run time
// Notes:   register calls follow the strobe protocol
`timescale 1ns/1ns
`include "bmms_defs.vh"
module bmms_top_tb;
	// ****************
	// signals
	// ****************
	logic        ref_clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
	logic [7:0]  reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, sys_addr_i, sys_offset_o, wbuf_data_o;
	logic        sys_valid_i, sys_hit_o, sys_err_o, sys_bitband_o, flash_op_o, flash_wide_o;
	logic [2:0]  sys_target_o, sys_bit_o, nonvolatile_config_bits_o, nvm_image_i = 3'h0;
	logic [1:0]  flash_op_kind_o;
	logic [9:0]  flash_page_o;
	logic [4:0]  wbuf_idx_i = 5'h00;
	logic        flash_busy_i = 1'b0, boot_flash_o, erase_fire_o, fpp_mode_o;
	logic        test_mode_pin_i = 1'b1, port_a_line_0_i = 1'b1, port_a_line_1_i = 1'b1;
	logic        fpp_cmd_valid_i = 1'b0, fpp_accept_o, fpp_reject_o;
	logic [3:0]  fpp_cmd_i = 4'h0, fpp_cmd_o;
	logic        erase_pin_i = 1'b0, erase_pin_gpio_i = 1'b0, hit;
	logic [2:0]  tgt;
	int          fail_count = 0, cmp_count = 0, fires = 0;

	always #20 ref_clk_i = ~ref_clk_i;
	bmms_top #(.SLOW_DIV(4), .ERASE_TICKS(3)) dut_u (.*);
	bmms_master_model mst_u (.clk_i(ref_clk_i), .sys_valid_o(sys_valid_i),
		.sys_addr_o(sys_addr_i), .sys_hit_i(sys_hit_o), .sys_target_i(sys_target_o));
	// erase events counted for press checks
	always @(posedge ref_clk_i) if (erase_fire_o === 1'b1) fires <= fires + 1;

	// ****************
	// tasks
	// ****************
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		reg_wr_i    <= 1'b1;
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
		@(negedge ref_clk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge ref_clk_i);
		reg_rd_i   <= 1'b1;
		reg_addr_i <= a;
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b0;
		@(negedge ref_clk_i);
		chk("read data", reg_rdata_o, exp);
	endtask
	task automatic dec(input logic [31:0] a, input logic eh, input logic [2:0] et);
		mst_u.access(a, hit, tgt);
		chk("decode hit", {31'h0, hit}, {31'h0, eh});
		chk("decode err", {31'h0, sys_err_o}, {31'h0, !eh});
		if (eh) chk("decode target", {29'h0, tgt}, {29'h0, et});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask
	task automatic do_reset(input logic [2:0] img);
		@(posedge ref_clk_i);
		rst_n_i     <= 1'b0;
		nvm_image_i <= img;
		cyc(16);
		rst_n_i <= 1'b1;
	endtask
	task automatic press(input int n);
		@(posedge ref_clk_i);
		erase_pin_i <= 1'b1;
		cyc(n);
		erase_pin_i <= 1'b0;
		cyc(8);
	endtask
	task automatic test_done;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ****************
	// sequence
	// ****************
	initial begin
		do_reset(3'h0);
		mst_u.boot_fetch(hit, tgt);
		chk("boot fetch", {29'h0, tgt}, 32'h2);
		rd(`BMMS_REG_CTRL, 32'h1);
		rd(`BMMS_REG_DESC, {16'h0400, 16'h0100});
		rd(8'h40, 32'h0);
		dec(32'h2000_5FFC, 1'b1, 3'h1);
		dec(32'h2000_6000, 1'b0, 3'h0);
		dec(32'h220B_FFFC, 1'b1, 3'h1);
		chk("alias offset", sys_offset_o, 32'h0000_5FFF);
		chk("alias bit", {29'h0, sys_bit_o}, 32'h7);
		dec(32'h23FF_FFFC, 1'b0, 3'h0);
		dec(32'h0080_0000, 1'b1, 3'h2);
		dec(32'h0000_4000, 1'b0, 3'h0);
		dec(32'h4000_0000, 1'b1, 3'h4);
		dec(32'h4200_0004, 1'b1, 3'h4);
		wr(`BMMS_REG_CTRL, 32'h0);
		chk("wide", {31'h0, flash_wide_o}, 32'h0);
		wr(`BMMS_REG_CTRL, 32'h1);
		chk("wide", {31'h0, flash_wide_o}, 32'h1);
		wr(`BMMS_REG_WBUF, 32'hA5A5_0001);
		wr(8'hFC, 32'h5A5A_001F);
		@(posedge ref_clk_i);
		wbuf_idx_i <= 5'h1F;
		cyc(2);
		@(negedge ref_clk_i);
		chk("buffer word", wbuf_data_o, 32'h5A5A_001F);
		rd(`BMMS_REG_WBUF, 32'hA5A5_0001);
		wr(`BMMS_REG_CMD, 32'h03FF_0003);
		chk("op kind page", {19'h0, flash_op_o, flash_op_kind_o, flash_page_o},
			{19'h0, 1'b1, 2'h1, 10'h3FF});
		@(posedge ref_clk_i);
		flash_busy_i <= 1'b1;
		wr(`BMMS_REG_CMD, 32'h0001_0004);
		chk("busy op", {31'h0, flash_op_o}, 32'h0);
		rd(`BMMS_REG_STAT, 32'h81);
		@(posedge ref_clk_i);
		flash_busy_i <= 1'b0;
		wr(`BMMS_REG_CMD, 32'h0005_0004);
		chk("erase op", {19'h0, flash_op_o, flash_op_kind_o, flash_page_o},
			{19'h0, 1'b1, 2'h2, 10'h005});
		wr(`BMMS_REG_CMD, 32'h0000_0301);
		rd(`BMMS_REG_STAT, 32'h01);
		for (int i = 0; i < 3; i++) begin
			wr(`BMMS_REG_CMD, {22'h0, 2'(i), 8'h01});
			chk("nv set", {29'h0, nonvolatile_config_bits_o}, 32'h1 << i);
			wr(`BMMS_REG_CMD, {22'h0, 2'(i), 8'h02});
			chk("nv clear", {29'h0, nonvolatile_config_bits_o}, 32'h0);
		end
		wr(`BMMS_REG_CMD, 32'h0000_0101);
		chk("boot held", {31'h0, boot_flash_o}, 32'h0);
		press(3);
		chk("short press", 32'(fires), 32'h0);
		erase_pin_gpio_i <= 1'b1;
		press(40);
		erase_pin_gpio_i <= 1'b0;
		chk("gpio press", 32'(fires), 32'h0);
		press(40);
		chk("long press", 32'(fires), 32'h1);
		chk("boot bit", {31'h0, nonvolatile_config_bits_o[1]}, 32'h0);
		do_reset(3'h2);
		cyc(1);
		chk("boot flash", {31'h0, boot_flash_o}, 32'h1);
		mst_u.boot_fetch(hit, tgt);
		chk("boot fetch", {29'h0, tgt}, 32'h3);
		dec(32'h0080_0000, 1'b1, 3'h2);
		@(posedge ref_clk_i);
		test_mode_pin_i <= 1'b0;
		port_a_line_0_i <= 1'b0;
		port_a_line_1_i <= 1'b0;
		cyc(2);
		@(negedge ref_clk_i);
		chk("fast mode", {31'h0, fpp_mode_o}, 32'h1);
		for (int c = 0; c < 9; c++) begin
			cyc(1);
			if (c == 8) port_a_line_1_i <= 1'b1;
			cyc(2);
			fpp_cmd_valid_i <= 1'b1;
			fpp_cmd_i       <= 4'(c % 8);
			@(posedge ref_clk_i);
			fpp_cmd_valid_i <= 1'b0;
			@(negedge ref_clk_i);
			chk("fast accept", {30'h0, fpp_accept_o, fpp_reject_o},
				(c < 7) ? 32'h2 : 32'h1);
		end
		test_done();
	end

	// hang guard, far beyond the expected few hundred cycles
	initial begin
		#2000000;
		fail_count++;
		test_done();
	end
endmodule // bmms_top_tb

bind bmms_top bmms_chk chk_u (.*);
